// >>> verification/sfs_assertions.sv
// Port assertions for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module sfs_assertions
    import sfs_pkg::*;
#(
    parameter int unsigned ERASE_US = ERASE_TIME_US,
    parameter int unsigned WRITE_US = WRITE_TIME_US
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        key_write,
    input wire logic [7:0]  key_value,
    input wire logic        upper_address_write,
    input wire logic        lower_address_write,
    input wire logic        control_write,
    input wire logic [15:0] control_value,
    input wire logic [15:0] flash_control_register,
    input wire logic [7:0]  upper_target_address,
    input wire logic [15:0] lower_target_address,
    input wire logic        cpu_stall,
    input wire logic        flash_erase_strobe,
    input wire logic        flash_program_strobe,
    input wire logic [23:0] flash_address,
    input wire logic        align_error
);
    logic [1:0]  key_step;
    logic [31:0] busy;
    logic [31:0] span;
    logic        start;
    logic        open;
    assign start = control_write && control_value[15] && !flash_control_register[15];
    assign open  = key_step == 2'h2;
    // Bit 0 holds the running op, so each op gets its own length
    assign span  = (flash_control_register[0] ? ERASE_US : WRITE_US) * CYCLES_PER_TICK;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Any other write relocks the key
    always_ff @(posedge clk) begin
        if (!rst_n || upper_address_write || lower_address_write || control_write) begin
            key_step <= 2'h0;
        end else if (key_write) begin
            key_step <= key_value == 8'h55 ? 2'h1 : (key_step == 2'h1 && key_value == 8'haa ? 2'h2 : 2'h0);
        end
    end
    always_ff @(posedge clk) begin
        busy <= rst_n && cpu_stall ? busy + 32'h1 : 32'h0;
    end
    a_stall_is_busy: assert property (cpu_stall == flash_control_register[15])
        else $error("stall and busy bit differ");
    a_locked_ignored: assert property (start && !open |=> !cpu_stall && !flash_control_register[15])
        else $error("start ran while locked");
    a_unlocked_runs: assert property (start && open && (control_value[0] || lower_target_address[1:0] == 2'h2)
        |=> cpu_stall && flash_erase_strobe == $past(control_value[0])
            && flash_program_strobe != $past(control_value[0])) else $error("unlocked start lost");
    a_misaligned_refused: assert property (start && open && !control_value[0] && lower_target_address[1:0] != 2'h2
        |=> align_error && !cpu_stall) else $error("misaligned program ran");
    a_strobe_single: assert property (flash_erase_strobe || flash_program_strobe
        |=> !flash_erase_strobe && !flash_program_strobe) else $error("strobe too long");
    a_address_joined: assert property ($rose(cpu_stall)
        |-> flash_address == {upper_target_address, lower_target_address}) else $error("target address wrong");
    a_busy_bounded: assert property (busy <= span + 8)
        else $error("busy bit never cleared");
    a_busy_full: assert property ($fell(cpu_stall) && $past(rst_n)
        |-> busy + 2 >= span) else $error("stall released early");
endmodule : sfs_assertions
bind sfs_sequencer sfs_assertions #(.ERASE_US(ERASE_US), .WRITE_US(WRITE_US)) i_sfs_assertions (.*);
`default_nettype wire

// >>> verification/sfs_cpu_model.sv
// Processor core model issuing sequencer writes
`timescale 1ns/1ps
`default_nettype none
module sfs_cpu_model (
    input  wire logic   clk,
    input  wire logic   cpu_stall,
    output logic        key_write,
    output logic [7:0]  key_value,
    output logic        upper_address_write,
    output logic [7:0]  upper_address_value,
    output logic        lower_address_write,
    output logic [15:0] lower_address_value,
    output logic        control_write,
    output logic [15:0] control_value,
    output logic [23:0] program_word_low,
    output logic [23:0] program_word_high
);
    initial begin
        {key_write, upper_address_write, lower_address_write, control_write} = 4'h0;
        {key_value, upper_address_value, lower_address_value, control_value, program_word_low, program_word_high} = '0;
    end
    task automatic wr(input logic [1:0] k, input logic [15:0] v);
        @(posedge clk);
        {key_write, upper_address_write, lower_address_write, control_write} <= 4'h8 >> k;
        {key_value, upper_address_value, lower_address_value, control_value} <= {v[7:0], v[7:0], v, v};
        @(posedge clk);
        {key_write, upper_address_write, lower_address_write, control_write} <= 4'h0;
        // Released fields no longer show the value
        {key_value, upper_address_value, lower_address_value, control_value} <= ~{v[7:0], v[7:0], v, v};
    endtask : wr
    task automatic op(input logic [23:0] a, input logic [15:0] c, input logic [15:0] k, input logic [47:0] w,
                      output int n);
        wr(2'h1, {8'h00, a[23:16]});
        wr(2'h2, a[15:0]);
        if (k != 16'h0) begin
            wr(2'h0, {8'h00, k[15:8]});
            wr(2'h0, {8'h00, k[7:0]});
        end
        {program_word_high, program_word_low} <= w;
        wr(2'h3, c);
        repeat (2) @(posedge clk);
        n = 0;
        while (cpu_stall !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
    endtask : op
endmodule : sfs_cpu_model
`default_nettype wire

// >>> verification/sfs_sequencer_bench.sv
// Self-checking bench for the flash sequencer
`timescale 1ns/1ps
`default_nettype none
module sfs_sequencer_bench
    import sfs_pkg::*;
;
    localparam int ERASE = 2;
    localparam int WRITE = 1;
    logic        clk, rst_n, key_write, upper_address_write, lower_address_write, control_write;
    logic        cpu_stall, flash_erase_strobe, flash_program_strobe, align_error;
    logic [7:0]  key_value, upper_address_value, upper_target_address;
    logic [15:0] lower_address_value, control_value, flash_control_register, lower_target_address;
    logic [23:0] program_word_low, program_word_high, flash_address, flash_data_low, flash_data_high;
    int          fails = 0;
    int          total_checks = 0;
    sfs_sequencer #(.ERASE_US(ERASE), .WRITE_US(WRITE)) i_sfs_sequencer (.*);
    sfs_cpu_model i_sfs_cpu_model (.*);
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string what);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    task automatic t_erase;
        int n;
        chk({flash_control_register, cpu_stall, align_error}, 64'h0, "reset state");
        i_sfs_cpu_model.op(24'h0a0400, 16'h8001, 16'h55aa, 48'h0, n);
        chk(n >= ERASE * CYCLES_PER_TICK - 2 && n <= ERASE * CYCLES_PER_TICK + 6, 1'b1, "erase time");
        chk({flash_address, flash_control_register}, {24'h0a0400, 16'h0001}, "erase page");
        chk({upper_target_address, lower_target_address}, 24'h0a0400, "address registers");
        $display("erase test done");
    endtask : t_erase
    task automatic t_program;
        int n;
        // Page erased just before, as software must
        i_sfs_cpu_model.op(24'h0a0406, 16'h8000, 16'h55aa, 48'h123456_abcdef, n);
        chk(n >= WRITE * CYCLES_PER_TICK - 2 && n <= WRITE * CYCLES_PER_TICK + 6, 1'b1, "write time");
        chk({flash_data_high, flash_data_low}, 48'h123456_abcdef, "word pair");
        chk({flash_address, flash_control_register, align_error}, {24'h0a0406, 17'h0}, "program done");
        $display("program test done");
    endtask : t_program
    task automatic t_refused;
        logic [23:0] adr [4] = '{24'h0a0402, 24'h0a0402, 24'h0a0402, 24'h0a0404};
        logic [15:0] key [4] = '{16'h0000, 16'haa55, 16'h5556, 16'h55aa};
        int n;
        for (int i = 0; i < 4; i++) begin
            i_sfs_cpu_model.op(adr[i], 16'h8000, key[i], 48'hffffff_ffffff, n);
            chk({n[7:0], flash_control_register, flash_address}, {8'h0, 16'h0, 24'h0a0406}, "start ran");
            chk(flash_data_low, 24'habcdef, "data changed");
            chk(align_error, i == 3, "align flag");
        end
        $display("refusal test done");
    endtask : t_refused
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_erase;
        t_program;
        t_refused;
        wrap_up;
    end
    // Whole run is well under a thousand cycles
    initial begin
        #200000;
        fails++;
        wrap_up;
    end
endmodule : sfs_sequencer_bench
`default_nettype wire

// >>> verilog/sfs_pkg.sv
// Shared constants for the self-programming flash sequencer
package sfs_pkg;
    localparam int unsigned CLOCK_KHZ        = 40000;
    localparam int unsigned TICK_NS          = 1000;
    localparam int unsigned CYCLES_PER_TICK  = (CLOCK_KHZ * TICK_NS) / 1000000;
    localparam int unsigned ERASE_TIME_US    = 20000;
    localparam int unsigned WRITE_TIME_US    = 50;
    localparam int unsigned ADDR_WIDTH       = 24;
    localparam int unsigned UPPER_WIDTH      = 8;
    localparam int unsigned LOWER_WIDTH      = 16;
    localparam int unsigned WORD_WIDTH       = 24;
    localparam int unsigned KEY_WIDTH        = 8;
    localparam int unsigned START_BIT_POS    = 15;
    localparam int unsigned OP_SELECT_POS    = 0;
    localparam logic [7:0]  KEY_FIRST        = 8'h55;
    localparam logic [7:0]  KEY_SECOND       = 8'haa;
    localparam logic [1:0]  PAIR_ALIGN_LSBS  = 2'h2;
    localparam logic [23:0] ADDRESS_RESET    = 24'h000000;
    localparam logic [15:0] CONTROL_RESET    = 16'h0000;

    typedef enum logic [2:0] {
        KEY_LOCKED = 3'h1,
        KEY_HALF   = 3'h2,
        KEY_OPEN   = 3'h4
    } sfs_key_type;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'h1,
        SEQ_ERASE = 3'h2,
        SEQ_WRITE = 3'h4
    } sfs_state_type;
endpackage : sfs_pkg

// >>> verilog/sfs_sequencer.sv
// Functional notes
// - Two operations: erase one page, or program two instruction words.
// - Processor held stalled until the flash operation has completed.
// - Start bit 15 launches the operation; hardware clears it when done.
// - Program writes an adjacent 24-bit word pair on pair-aligned addresses.
// - Unlock sequence must come immediately before every start.
// - Unlock is 0x55 then 0xAA, consecutive; anything else stays locked.
// - Key register is write-only; no key value is ever returned.
// - Target address is upper 8 bits joined with lower 16 bits.
`timescale 1ns/1ps
`default_nettype none
module sfs_sequencer
    import sfs_pkg::*;
#(
    parameter int unsigned ERASE_US = ERASE_TIME_US,
    parameter int unsigned WRITE_US = WRITE_TIME_US
) (
    input  wire logic                   clk,
    input  wire logic                   rst_n,
    input  wire logic                   key_write,
    input  wire logic [KEY_WIDTH-1:0]   key_value,
    input  wire logic                   upper_address_write,
    input  wire logic [UPPER_WIDTH-1:0] upper_address_value,
    input  wire logic                   lower_address_write,
    input  wire logic [LOWER_WIDTH-1:0] lower_address_value,
    input  wire logic                   control_write,
    input  wire logic [15:0]            control_value,
    input  wire logic [WORD_WIDTH-1:0]  program_word_low,
    input  wire logic [WORD_WIDTH-1:0]  program_word_high,
    output logic [15:0]                 flash_control_register,
    output logic [UPPER_WIDTH-1:0]      upper_target_address,
    output logic [LOWER_WIDTH-1:0]      lower_target_address,
    output logic                        cpu_stall,
    output logic                        flash_erase_strobe,
    output logic                        flash_program_strobe,
    output logic [ADDR_WIDTH-1:0]       flash_address,
    output logic [WORD_WIDTH-1:0]       flash_data_low,
    output logic [WORD_WIDTH-1:0]       flash_data_high,
    output logic                        align_error
);
    sfs_key_type   key_state;
    sfs_key_type   next_key_state;
    sfs_state_type state;
    logic          start_request;
    logic          op_done;
    logic          erase_select;
    logic          accept;
    logic          pair_aligned;
    logic [ADDR_WIDTH-1:0] target;

    sfs_timer_if timer_bus ();

    sfs_timer u_timer (
        .clk   (clk),
        .rst_n (rst_n),
        .bus   (timer_bus.timer)
    );

    // Bit 0 of the control word picks erase; bits 14 to 1 read as zero
    assign start_request = control_write && control_value[START_BIT_POS];
    assign erase_select  = control_value[OP_SELECT_POS];
    // Target address joins upper and lower registers
    assign target        = {upper_target_address, lower_target_address};
    assign pair_aligned  = (target[1:0] == PAIR_ALIGN_LSBS);
    // Timer end only counts while an operation runs
    assign op_done       = (state != SEQ_IDLE) && timer_bus.done;
    // Start honoured only when idle and unlocked
    assign accept        = start_request && (state == SEQ_IDLE) && (key_state == KEY_OPEN)
                           && (erase_select || pair_aligned);

    always_comb begin
        next_key_state = key_state;
        if (key_write) begin
            case (key_state)
                KEY_LOCKED: begin
                    next_key_state = (key_value == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                end
                KEY_HALF: begin
                    if (key_value == KEY_SECOND) begin
                        next_key_state = KEY_OPEN;
                    end else if (key_value == KEY_FIRST) begin
                        next_key_state = KEY_HALF;
                    end else begin
                        next_key_state = KEY_LOCKED;
                    end
                end
                default: begin
                    next_key_state = (key_value == KEY_FIRST) ? KEY_HALF : KEY_LOCKED;
                end
            endcase
        end else if (control_write || upper_address_write || lower_address_write) begin
            // Any other write between key and start relocks
            next_key_state = KEY_LOCKED;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            key_state <= KEY_LOCKED;
        end else begin
            key_state <= next_key_state;
        end
    end

    // address registers
    // Frozen while busy so the latched target holds
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            upper_target_address <= ADDRESS_RESET[ADDR_WIDTH-1:LOWER_WIDTH];
            lower_target_address <= ADDRESS_RESET[LOWER_WIDTH-1:0];
        end else if (state == SEQ_IDLE) begin
            if (upper_address_write) begin
                upper_target_address <= upper_address_value;
            end
            if (lower_address_write) begin
                lower_target_address <= lower_address_value;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= SEQ_IDLE;
        end else begin
            case (state)
                SEQ_IDLE: begin
                    if (accept) begin
                        state <= erase_select ? SEQ_ERASE : SEQ_WRITE;
                    end
                end
                SEQ_ERASE: begin
                    if (timer_bus.done) begin
                        state <= SEQ_IDLE;
                    end
                end
                SEQ_WRITE: begin
                    if (timer_bus.done) begin
                        state <= SEQ_IDLE;
                    end
                end
                default: state <= SEQ_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timer_bus.launch <= 1'b0;
            timer_bus.length <= 32'h00000000;
        end else begin
            timer_bus.launch <= accept;
            // Length rides with launch on one edge
            if (accept) begin
                timer_bus.length <= erase_select ? ERASE_US : WRITE_US;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flash_control_register <= CONTROL_RESET;
        end else if (accept) begin
            flash_control_register <= CONTROL_RESET | (16'h0001 << START_BIT_POS)
                                      | (16'(erase_select) << OP_SELECT_POS);
        end else if (op_done) begin
            flash_control_register[START_BIT_POS] <= 1'b0;
        end else if (control_write && state == SEQ_IDLE) begin
            // Refused start keeps the op select, never bit 15
            flash_control_register <= 16'(control_value[OP_SELECT_POS]) << OP_SELECT_POS;
        end
    end

    // stall released with the start bit
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpu_stall <= 1'b0;
        end else if (accept) begin
            cpu_stall <= 1'b1;
        end else if (op_done) begin
            cpu_stall <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flash_erase_strobe   <= 1'b0;
            flash_program_strobe <= 1'b0;
        end else begin
            flash_erase_strobe   <= accept && erase_select;
            flash_program_strobe <= accept && !erase_select;
        end
    end

    // word pair and target latched
    // Only an accepted start touches the flash side
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            flash_address   <= ADDRESS_RESET;
            flash_data_low  <= {WORD_WIDTH{1'b0}};
            flash_data_high <= {WORD_WIDTH{1'b0}};
        end else if (accept) begin
            flash_address   <= target;
            flash_data_low  <= program_word_low;
            flash_data_high <= program_word_high;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            align_error <= 1'b0;
        end else if (start_request && state == SEQ_IDLE && key_state == KEY_OPEN) begin
            align_error <= !erase_select && !pair_aligned;
        end
    end
endmodule : sfs_sequencer
`default_nettype wire

// >>> verilog/sfs_timer.sv
// Flash operation duration timer counting microsecond ticks
`timescale 1ns/1ps
`default_nettype none
module sfs_timer
    import sfs_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = CYCLES_PER_TICK
) (
    input  wire logic  clk,
    input  wire logic  rst_n,
    sfs_timer_if.timer bus
);
    logic [31:0] prescale;
    logic [31:0] remaining;
    logic        running;
    logic        tick;

    // Microsecond enable keeps the long erase count narrow
    always_ff @(posedge clk) begin
        if (!rst_n || bus.launch || !running) begin
            prescale <= 32'h00000000;
            tick     <= 1'b0;
        end else if (prescale == TICK_CYCLES - 1) begin
            prescale <= 32'h00000000;
            tick     <= 1'b1;
        end else begin
            prescale <= prescale + 32'h00000001;
            tick     <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            running   <= 1'b0;
            remaining <= 32'h00000000;
            bus.done  <= 1'b0;
        end else if (bus.launch) begin
            running   <= 1'b1;
            remaining <= bus.length;
            bus.done  <= 1'b0;
        end else if (running && tick) begin
            if (remaining <= 32'h00000001) begin
                running  <= 1'b0;
                bus.done <= 1'b1;
            end else begin
                remaining <= remaining - 32'h00000001;
            end
        end else begin
            bus.done <= 1'b0;
        end
    end
endmodule : sfs_timer
`default_nettype wire

// >>> verilog/sfs_timer_if.sv
// Carrier between the sequencer and its duration timer
`timescale 1ns/1ps
`default_nettype none
interface sfs_timer_if;
    logic        launch;
    logic [31:0] length;
    logic        done;
    modport seq   (output launch, output length, input done);
    modport timer (input launch, input length, output done);
endinterface : sfs_timer_if
`default_nettype wire
